// File: hdl/dbsp_pkg.sv
package dbsp_pkg;

   // ****************************************
   // Data word and byte lanes
   // ****************************************
   localparam int DATA_W = 18;
   localparam int LANES = 2;
   localparam int LANE_W = 9;
   localparam int ADDR_W = 8;
   localparam int BEATS = 2;

   // ****************************************
   // Timing
   // ****************************************
   localparam int SYS_CLK_NS = 50;
   localparam int PLL_LOCK_US = 100;
   localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000 + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int PLL_STOP_NS = 30;
   localparam int PLL_STOP_CYC_MIN = (PLL_STOP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int PLL_STALL_CYC = 16;
   localparam int IMP_RECAL_PERIOD = 1024;
   localparam int RANGE_CAPTURE_CYC = 3;

   // ****************************************
   // Array sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      AS_IDLE = 3'h0,
      AS_COMMIT0 = 3'h1,
      AS_COMMIT1 = 3'h3,
      AS_READ0 = 3'h2,
      AS_READ1 = 3'h6,
      AS_READ2 = 3'h7
   } dbsp_arr_state_t;

endpackage

// File: hdl/dbsp_mem.sv
`timescale 1ns/1ps
module dbsp_mem #(
   parameter int AW = 9,
   parameter int DW = 18
) (
   // Clock
   input wire logic clock,
   input wire logic arst_n,
   // Access
   input wire logic [dbsp_pkg::LANES-1:0] we,
   input wire logic re,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [2**AW];
   logic [DW-1:0] bmask;

   genvar i;
   generate
      for (i = 0; i < dbsp_pkg::LANES; i++) begin : g_lane
         assign bmask[i*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] = {dbsp_pkg::LANE_W{we[i]}};
      end
   endgenerate

   // Unselected lanes keep their stored bits
   always_ff @(posedge clock) begin
      if (|we) begin
         mem[addr] <= (mem[addr] & ~bmask) | (wdata & bmask);
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= '0;
      end else if (re) begin
         rdata <= mem[addr];
      end
   end

endmodule

// File: hdl/dbsp_fifo.sv
`timescale 1ns/1ps
module dbsp_fifo #(
   parameter int W = 18,
   parameter int DEPTH = 2
) (
   // Clock
   input wire logic clock,
   input wire logic arst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   // Status
   output logic full,
   output logic empty
);

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [PW:0] cnt;
   } dbsp_fifo_state_t;

   dbsp_fifo_state_t r;
   dbsp_fifo_state_t n;
   logic push;
   logic pop;

   assign full = (r.cnt == (PW+1)'(DEPTH));
   assign empty = (r.cnt == '0);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = r.mem[r.rptr];
   assign push = in_valid & ~full;
   assign pop = out_ready & ~empty;

   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wptr] = in_data;
         n.wptr = (r.wptr == PW'(DEPTH - 1)) ? '0 : r.wptr + 1'b1;
      end
      if (pop) begin
         n.rptr = (r.rptr == PW'(DEPTH - 1)) ? '0 : r.rptr + 1'b1;
      end
      n.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

endmodule

// File: hdl/dbsp_top.sv
// Summary of operation
// R1 - Lane selects sampled with every data beat
// R2 - Inactive lane leaves stored bits unchanged
// R3 - Controller idles two cycles before write
// R4 - Last write held in registers, posted
// R5 - Next write commits held write to array
// R6 - Read of held address forwarded from registers
// R7 - Each bank gets its own access select
// R8 - Impedance recalibrated every 1024 clock cycles
// R9 - Two free-running echo clocks from inputs
// R10 - Valid flag leads read data half cycle
// R11 - Termination on only during write data
// R12 - Termination range latched once after power-up
// R13 - PLL locks 100 us after stable clock
// R14 - Stopping clocks resets PLL, optional
// R15 - PLL off gives one-cycle read latency
// R16 - Write data on both rises of t+1
// R17 - Read data at t+2 negative, t+3 positive
// R18 - Deselected cycle is no operation, outputs float
// R19 - Power-up deselected with outputs floating
// R20 - Stopped clocks keep previous output state
// R21 - Select 0 gates [8:0], 1 gates [17:9]
// R22 - Lane selects may change between beats
// R23 - Burst covers A then A+1
`timescale 1ns/1ps
module dbsp_top #(
   parameter int AW = dbsp_pkg::ADDR_W,
   parameter int LOCK_CYC = dbsp_pkg::PLL_LOCK_CYC,
   parameter int STALL_CYC = dbsp_pkg::PLL_STALL_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Input clock pair
   input wire logic link_clk_p,
   input wire logic link_clk_n,
   // Command
   input wire logic access_select_n,
   input wire logic read_not_write,
   input wire logic [AW-1:0] addr,
   // Data
   input wire logic [dbsp_pkg::LANES-1:0] byte_lane_select_n,
   input wire logic [dbsp_pkg::DATA_W-1:0] dq_in,
   output logic [dbsp_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe_n,
   // Echo clocks and valid
   output logic echo_strobe_true,
   output logic echo_strobe_comp,
   output logic output_valid_flag,
   // Configuration and status
   input wire logic pll_enable_n_pin,
   input wire logic termination_range_sel,
   output logic term_enable,
   output logic term_range_high,
   output logic pll_locked,
   output logic imp_recal_pulse
);

   localparam int DW = dbsp_pkg::DATA_W;
   localparam int LW = dbsp_pkg::LANES;
   localparam int LCK_W = $clog2(LOCK_CYC + 1);
   localparam int STL_W = $clog2(STALL_CYC + 1);
   localparam int RC_W = $clog2(dbsp_pkg::IMP_RECAL_PERIOD);

   typedef struct packed {
      logic k_s1, k_s2, k_s3, kn_s1, kn_s2, kn_s3;
      logic sel_s1, sel_s2, rw_s1, rw_s2, pll_s1, pll_s2, rng_s1, rng_s2;
      logic [AW-1:0] addr_s1, addr_s2;
      logic [LW-1:0] bls_s1, bls_s2;
      logic [DW-1:0] dq_s1, dq_s2;
      logic [LCK_W-1:0] lock_cnt;
      logic locked;
      logic [STL_W-1:0] idle_cnt;
      logic [RC_W-1:0] recal_cnt;
      logic recal;
      logic [1:0] rng_cnt;
      logic rng_done, rng_high;
      logic echo_t, echo_c;
      logic pend_b0, pend_b1, term_en, cm_req;
      logic [AW-1:0] cmd_addr, in_addr, hold_addr, f_addr;
      logic [1:0][DW-1:0] in_data, hold_data;
      logic [1:0][LW-1:0] in_mask, hold_mask;
      logic hold_vld;
      logic [1:0][AW-1:0] rq_addr;
      logic [1:0] rq_cnt;
      logic [2:0] rd_pipe;
      dbsp_pkg::dbsp_arr_state_t ast;
      logic [DW-1:0] dq;
      logic oe_n, valid;
   } dbsp_state_t;

   dbsp_state_t r;
   dbsp_state_t n;

   logic rise_k, rise_kn, pll_on, cmd, cmd_wr, cmd_rd, hit;
   logic [LW-1:0] mem_we;
   logic mem_re;
   logic [AW:0] mem_addr;
   logic [DW-1:0] mem_wdata, mem_rdata;
   logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready, buf_empty;
   logic [DW-1:0] buf_in_data, buf_out_data;
   logic fetch_start;

   function automatic logic [DW-1:0] merge(input logic [DW-1:0] arr, input logic [DW-1:0] hld,
                                           input logic [LW-1:0] en);
      logic [DW-1:0] res;
      res = arr;
      for (int i = 0; i < LW; i++) begin
         if (en[i]) begin
            res[i*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] = hld[i*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W];
         end
      end
      return res;
   endfunction

   // ****************************************
   // Edge detection and command decode
   // ****************************************
   assign rise_k = r.k_s2 & ~r.k_s3;
   assign rise_kn = r.kn_s2 & ~r.kn_s3;
   assign pll_on = r.pll_s2;
   assign cmd = rise_k & ~r.sel_s2 & (~pll_on | r.locked); // [R18] [R13]
   assign cmd_wr = cmd & ~r.rw_s2;
   assign cmd_rd = cmd & r.rw_s2;
   assign hit = r.hold_vld & (r.hold_addr == r.f_addr);

   always_comb begin
      n = r;
      {mem_we, mem_re, mem_addr, mem_wdata} = '0;
      {buf_in_valid, buf_in_data, buf_out_ready, fetch_start} = '0;
      // Two-stage synchronisers on every pin
      {n.k_s1, n.kn_s1, n.sel_s1, n.rw_s1, n.pll_s1, n.rng_s1} = {link_clk_p, link_clk_n,
         access_select_n, read_not_write, pll_enable_n_pin, termination_range_sel};
      {n.k_s2, n.kn_s2, n.sel_s2, n.rw_s2, n.pll_s2, n.rng_s2} = {r.k_s1, r.kn_s1, r.sel_s1,
         r.rw_s1, r.pll_s1, r.rng_s1};
      {n.k_s3, n.kn_s3} = {r.k_s2, r.kn_s2};
      {n.addr_s1, n.bls_s1, n.dq_s1} = {addr, byte_lane_select_n, dq_in};
      {n.addr_s2, n.bls_s2, n.dq_s2} = {r.addr_s1, r.bls_s1, r.dq_s1};

      // ****************************************
      // PLL lock and stall detect
      // ****************************************
      if (rise_k | rise_kn) begin
         n.idle_cnt = '0;
      end else if (r.idle_cnt != STL_W'(STALL_CYC)) begin
         n.idle_cnt = r.idle_cnt + 1'b1;
      end
      // Stalled input clocks restart the lock wait
      if (!pll_on || r.idle_cnt == STL_W'(STALL_CYC)) begin // [R14]
         n.lock_cnt = '0;
         n.locked = 1'b0;
      end else if (!r.locked) begin
         n.lock_cnt = r.lock_cnt + 1'b1;
         if (r.lock_cnt == LCK_W'(LOCK_CYC - 1)) begin // [R13]
            n.locked = 1'b1;
         end
      end

      // ****************************************
      // Impedance recalibration, range, echo
      // ****************************************
      n.recal = 1'b0;
      if (rise_k) begin
         n.recal_cnt = r.recal_cnt + 1'b1;
         n.recal = (r.recal_cnt == RC_W'(dbsp_pkg::IMP_RECAL_PERIOD - 1)); // [R8]
      end
      if (!r.rng_done) begin
         n.rng_cnt = r.rng_cnt + 1'b1;
         if (r.rng_cnt == 2'(dbsp_pkg::RANGE_CAPTURE_CYC)) begin
            n.rng_done = 1'b1;
            n.rng_high = r.rng_s2; // [R12]
         end
      end
      n.echo_t = r.k_s2; // [R9] [R20]
      n.echo_c = r.kn_s2;

      // ****************************************
      // Array sequencer
      // ****************************************
      unique case (r.ast)
         dbsp_pkg::AS_IDLE: begin
            if (r.cm_req) begin
               n.ast = dbsp_pkg::AS_COMMIT0;
            end else if (r.rq_cnt != 2'h0 && !r.pend_b0 && !r.pend_b1 && buf_empty) begin
               fetch_start = 1'b1;
               n.f_addr = r.rq_addr[0];
               n.ast = dbsp_pkg::AS_READ0;
            end
         end
         dbsp_pkg::AS_COMMIT0: begin
            mem_we = r.hold_vld ? r.hold_mask[0] : '0; // [R5] [R2] [R21]
            mem_addr = {r.hold_addr, 1'b0};
            mem_wdata = r.hold_data[0];
            n.ast = dbsp_pkg::AS_COMMIT1;
         end
         dbsp_pkg::AS_COMMIT1: begin
            mem_we = r.hold_vld ? r.hold_mask[1] : '0; // [R5] [R23]
            mem_addr = {r.hold_addr, 1'b1};
            mem_wdata = r.hold_data[1];
            // The newest write stays posted until the next one
            n.hold_addr = r.in_addr; // [R4]
            n.hold_data = r.in_data;
            n.hold_mask = r.in_mask;
            n.hold_vld = 1'b1;
            n.cm_req = 1'b0;
            n.ast = dbsp_pkg::AS_IDLE;
         end
         dbsp_pkg::AS_READ0: begin
            mem_re = 1'b1;
            mem_addr = {r.f_addr, 1'b0};
            n.ast = dbsp_pkg::AS_READ1;
         end
         dbsp_pkg::AS_READ1: begin
            if (buf_in_ready) begin
               buf_in_valid = 1'b1;
               buf_in_data = merge(mem_rdata, r.hold_data[0], hit ? r.hold_mask[0] : '0); // [R6]
               mem_re = 1'b1;
               mem_addr = {r.f_addr, 1'b1}; // [R23]
               n.ast = dbsp_pkg::AS_READ2;
            end
         end
         dbsp_pkg::AS_READ2: begin
            if (buf_in_ready) begin
               buf_in_valid = 1'b1;
               buf_in_data = merge(mem_rdata, r.hold_data[1], hit ? r.hold_mask[1] : '0); // [R6]
               n.ast = dbsp_pkg::AS_IDLE;
            end
         end
         default: n.ast = dbsp_pkg::AS_IDLE;
      endcase

      // ****************************************
      // Write command and data beats
      // ****************************************
      if (rise_k) begin
         n.pend_b0 = cmd_wr; // [R16]
         if (cmd_wr) begin
            n.cmd_addr = r.addr_s2;
         end
         n.pend_b1 = r.pend_b0;
         if (r.pend_b0) begin
            n.in_addr = r.cmd_addr;
            n.in_data[0] = r.dq_s2; // [R1] [R22]
            n.in_mask[0] = ~r.bls_s2;
         end
      end
      if (rise_kn && r.pend_b1) begin
         n.pend_b1 = 1'b0;
         n.in_data[1] = r.dq_s2; // [R1] [R22]
         n.in_mask[1] = ~r.bls_s2;
         n.cm_req = 1'b1; // [R5]
      end
      n.term_en = n.pend_b0 | n.pend_b1; // [R11]

      // ****************************************
      // Read queue and output timing
      // ****************************************
      if (fetch_start) begin
         n.rq_addr[0] = r.rq_addr[1];
         n.rq_cnt = r.rq_cnt - 1'b1;
      end
      if (cmd_rd && n.rq_cnt != 2'h2) begin
         n.rq_addr[n.rq_cnt[0]] = r.addr_s2;
         n.rq_cnt = n.rq_cnt + 1'b1;
      end
      if (rise_k) begin
         n.rd_pipe = {r.rd_pipe[1:0], cmd_rd};
      end
      if (pll_on) begin
         if (rise_kn) begin
            n.oe_n = ~r.rd_pipe[2]; // [R17] [R18]
            buf_out_ready = r.rd_pipe[2];
         end
         if (rise_k) begin
            n.valid = r.rd_pipe[1]; // [R10]
            if (r.rd_pipe[2]) begin
               n.oe_n = 1'b0; // [R17]
               buf_out_ready = 1'b1;
            end
         end
      end else begin
         if (rise_k) begin
            n.oe_n = ~r.rd_pipe[0]; // [R15]
            buf_out_ready = r.rd_pipe[0];
         end
         if (rise_kn) begin
            n.valid = r.rd_pipe[0]; // [R10]
            if (r.rd_pipe[1]) begin
               n.oe_n = 1'b0; // [R15]
               buf_out_ready = 1'b1;
            end
         end
      end
      if (buf_out_ready && buf_out_valid) begin
         n.dq = buf_out_data;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.sel_s1 <= 1'b1;
         r.sel_s2 <= 1'b1;
         r.oe_n <= 1'b1; // [R19]
      end else begin
         r <= n;
      end
   end

   // ****************************************
   // Array and read buffer
   // ****************************************
   dbsp_mem #(.AW(AW + 1), .DW(DW)) u_mem (.clock(clock), .arst_n(arst_n), .we(mem_we),
      .re(mem_re), .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata));

   dbsp_fifo #(.W(DW), .DEPTH(2)) u_buf (.clock(clock), .arst_n(arst_n),
      .in_valid(buf_in_valid), .in_ready(buf_in_ready), .in_data(buf_in_data),
      .out_valid(buf_out_valid), .out_ready(buf_out_ready), .out_data(buf_out_data),
      .full(), .empty(buf_empty));

   assign {dq_out, dq_oe_n, echo_strobe_true, echo_strobe_comp, output_valid_flag} =
      {r.dq, r.oe_n, r.echo_t, r.echo_c, r.valid};
   assign {term_enable, term_range_high, pll_locked, imp_recal_pulse} =
      {r.term_en, r.rng_high, r.locked, r.recal};

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   lane_gate_a: assert property (r.ast == dbsp_pkg::AS_COMMIT0 |-> // [R21]
      mem_we == (r.hold_vld ? r.hold_mask[0] : 2'h0) && mem_addr[0] == 1'b0)
      else $error("commit lane enables wrong");
   commit_post_a: assert property (r.ast == dbsp_pkg::AS_COMMIT1 |=> // [R5]
      r.hold_vld && r.hold_addr == $past(r.in_addr) && r.ast == dbsp_pkg::AS_IDLE)
      else $error("posted write not moved to holding");
   read_late_a: assert property (pll_on && rise_kn && r.rd_pipe[2] |=> // [R17]
      !dq_oe_n && dq_out == $past(buf_out_data))
      else $error("read word not driven on negative rise");
   nop_float_a: assert property (pll_on && rise_kn && !r.rd_pipe[2] |=> dq_oe_n) // [R18]
      else $error("data driven without read");
   valid_lead_a: assert property (pll_on && $rose(output_valid_flag) |-> // [R10]
      dq_oe_n ##1 (dq_oe_n || !output_valid_flag) [*3])
      else $error("valid not ahead of data");
   term_write_a: assert property (term_enable |-> !output_valid_flag) // [R11]
      else $error("termination on during read");
   recal_cnt_a: assert property (imp_recal_pulse |-> r.recal_cnt == '0 && // [R8]
      $past(rise_k)) else $error("recalibration out of period");
   range_once_a: assert property (r.rng_done && $past(r.rng_done) |-> // [R12]
      $stable(term_range_high)) else $error("range changed after capture");
   fwd_hit_a: assert property (r.ast == dbsp_pkg::AS_READ1 && buf_in_valid && hit && // [R6]
      r.hold_mask[0] == 2'h3 |-> buf_in_data == r.hold_data[0])
      else $error("forwarding missed held data");
   legacy_lat_a: assert property (!pll_on && rise_k && r.rd_pipe[0] |=> !dq_oe_n) // [R15]
      else $error("legacy latency wrong");

   write_c: cover property (r.ast == dbsp_pkg::AS_COMMIT1 && r.hold_vld);
   read_c: cover property (rise_kn && r.rd_pipe[2] && pll_on);
   fwd_c: cover property (r.ast == dbsp_pkg::AS_READ1 && hit);
   stall_c: cover property (r.ast == dbsp_pkg::AS_READ1 && !buf_in_ready);

endmodule

// File: verif/dbsp_ctl_model.sv
`timescale 1ns/1ps
module dbsp_ctl_model (
   // Clock
   input wire logic clock,
   // Link pins
   output logic link_clk_p,
   output logic link_clk_n,
   output logic access_select_n,
   output logic read_not_write,
   output logic [dbsp_pkg::ADDR_W-1:0] addr,
   output logic [dbsp_pkg::LANES-1:0] byte_lane_select_n,
   output logic [dbsp_pkg::DATA_W-1:0] dq_in,
   // Device answers
   input wire logic [dbsp_pkg::DATA_W-1:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic output_valid_flag,
   input wire logic term_enable
);
   // ********
   // Link clock, eight system clocks a period
   // ********
   logic [2:0] ph_reg = 3'h0;
   logic hold = 1'b0;
   logic halted = 1'b0;
   always @(posedge clock) ph_reg <= ph_reg + 3'h1;
   // Parked high while halted for the quickest restart
   assign link_clk_p = halted | (ph_reg < 3'h4);
   assign link_clk_n = halted | (ph_reg > 3'h3);
   initial begin
      access_select_n = 1'b1;
      read_not_write = 1'b0;
      addr = '0;
      byte_lane_select_n = '0;
      dq_in = '0;
   end
   // Released lines toggle and the select parks high, so a stale value never passes for data
   always @(posedge clock) begin
      if (!hold && (ph_reg == 3'h1 || ph_reg == 3'h5)) begin
         access_select_n <= 1'b1;
         read_not_write <= ~read_not_write;
         addr <= ~addr;
         byte_lane_select_n <= ~byte_lane_select_n;
         dq_in <= ~dq_in;
      end
   end
   // ********
   // Transfers
   // ********
   task automatic at(input logic [2:0] p);
      @(posedge clock iff ph_reg == p);
   endtask
   // Command set up a quarter cycle before K rise t, dropped after it
   task automatic cmd(input logic rd, input logic [dbsp_pkg::ADDR_W-1:0] a);
      at(3'h3);
      hold = 1'b1;
      at(3'h5);
      access_select_n <= 1'b0;
      read_not_write <= rd;
      addr <= a;
      at(3'h1);
      access_select_n <= 1'b1;
      read_not_write <= ~rd;
      addr <= ~a;
   endtask
   task automatic wr(input logic [dbsp_pkg::ADDR_W-1:0] a, input logic [17:0] d0,
                     input logic [17:0] d1, input logic [1:0] m0, input logic [1:0] m1,
                     output logic ton, output logic toff);
      cmd(1'b0, a);
      at(3'h5);
      dq_in <= d0;
      byte_lane_select_n <= m0;
      at(3'h1);
      ton = term_enable;
      dq_in <= d1;
      byte_lane_select_n <= m1;
      at(3'h3);
      hold = 1'b0;
      at(3'h1);
      toff = ~term_enable;
   endtask
   // Samples sit mid-window so the 2..3 clock sync spread never matters
   task automatic rd(input logic [dbsp_pkg::ADDR_W-1:0] a, input logic byp,
                     output logic [17:0] q0, output logic [17:0] q1,
                     output logic lead, output logic done, output logic term);
      cmd(1'b1, a);
      at(3'h3);
      hold = 1'b0;
      if (byp) begin
         at(3'h1);
      end else begin
         repeat (3) at(3'h5);
      end
      lead = output_valid_flag & dq_oe_n;
      term = term_enable;
      at(byp ? 3'h5 : 3'h1);
      q0 = dq_out;
      at(byp ? 3'h1 : 3'h5);
      q1 = dq_out;
      at(byp ? 3'h5 : 3'h1);
      done = dq_oe_n;
   endtask
   task automatic halt(input int n);
      at(3'h3);
      halted <= 1'b1;
      repeat (n) @(posedge clock);
      halted <= 1'b0;
   endtask
endmodule

// File: verif/dbsp_top_bench.sv
`timescale 1ns/1ps
module dbsp_top_bench;
   localparam int LOCK = 40;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic pll_enable_n_pin = 1'b1;
   logic termination_range_sel = 1'b1;
   logic link_clk_p, link_clk_n, access_select_n, read_not_write;
   logic [dbsp_pkg::ADDR_W-1:0] addr;
   logic [1:0] byte_lane_select_n;
   logic [17:0] dq_in, dq_out;
   logic dq_oe_n, echo_strobe_true, echo_strobe_comp, output_valid_flag;
   logic term_enable, term_range_high, pll_locked, imp_recal_pulse;
   int mismatches = 0;
   int samples_checked = 0;
   logic [17:0] ref_mem [0:511];
   always #25 clock = ~clock;
   dbsp_top #(.LOCK_CYC(LOCK)) dut (.clock, .arst_n, .link_clk_p, .link_clk_n,
      .access_select_n, .read_not_write, .addr, .byte_lane_select_n, .dq_in, .dq_out,
      .dq_oe_n, .echo_strobe_true, .echo_strobe_comp, .output_valid_flag, .pll_enable_n_pin,
      .termination_range_sel, .term_enable, .term_range_high, .pll_locked, .imp_recal_pulse);
   dbsp_ctl_model ctl (.clock, .link_clk_p, .link_clk_n, .access_select_n, .read_not_write,
      .addr, .byte_lane_select_n, .dq_in, .dq_out, .dq_oe_n, .output_valid_flag, .term_enable);
   // ********
   // Helpers
   // ********
   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n,
                                         input logic [1:0] m);
      merge = o;
      if (!m[0]) merge[8:0] = n[8:0];
      if (!m[1]) merge[17:9] = n[17:9];
   endfunction
   task automatic wr(input logic [7:0] a, input logic [17:0] d0, input logic [17:0] d1,
                     input logic [1:0] m0, input logic [1:0] m1);
      logic ton, toff;
      ref_mem[{a, 1'b0}] = merge(ref_mem[{a, 1'b0}], d0, m0);
      ref_mem[{a, 1'b1}] = merge(ref_mem[{a, 1'b1}], d1, m1);
      ctl.wr(a, d0, d1, m0, m1, ton, toff);
      check(18'(ton), 18'h00001);
      check(18'(toff), 18'h00001);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic byp);
      logic [17:0] q0, q1;
      logic lead, done, term;
      ctl.rd(a, byp, q0, q1, lead, done, term);
      check(q0, ref_mem[{a, 1'b0}]);
      check(q1, ref_mem[{a, 1'b1}]);
      check(18'(lead), 18'h00001);
      check(18'(done), 18'h00001);
      check(18'(term), 18'h00000);
   endtask
   task automatic wait_lock(output int n);
      n = 0;
      while (pll_locked !== 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      check(18'(pll_locked), 18'h00001);
      if (pll_locked !== 1'b1) summarize();
   endtask
   // ********
   // Scenarios
   // ********
   task automatic t_start();
      int n;
      repeat (2) @(posedge clock);
      check(18'(dq_oe_n), 18'h00001);
      check(18'(pll_locked), 18'h00000);
      repeat (8) @(posedge clock);
      termination_range_sel <= 1'b0;
      repeat (8) @(posedge clock);
      check(18'(term_range_high), 18'h00001);
      wait_lock(n);
      check(18'(n + 18 >= LOCK), 18'h00001);
      ctl.at(3'h5);
      check(18'({echo_strobe_true, echo_strobe_comp}), 18'h00002);
      ctl.at(3'h1);
      check(18'({echo_strobe_true, echo_strobe_comp}), 18'h00001);
   endtask
   // Held write read back, then committed by the next write
   task automatic t_posted();
      wr(8'h10, 18'h12345, 18'h2ABCD, 2'h0, 2'h0);
      rd_chk(8'h10, 1'b0);
      wr(8'h11, 18'h00F0F, 18'h3C3C3, 2'h0, 2'h0);
      rd_chk(8'h10, 1'b0);
      rd_chk(8'h11, 1'b0);
      repeat (16) begin
         @(posedge clock);
         check(18'(dq_oe_n), 18'h00001);
      end
   endtask
   // Every lane code, different on the two beats
   task automatic t_masks();
      wr(8'h20, 18'h3FFFF, 18'h00000, 2'h0, 2'h0);
      for (int m = 0; m < 4; m++) begin
         wr(8'h20, 18'h15A5A ^ 18'(m), 18'h2A5A5 ^ 18'(m), 2'(m), 2'(~m));
         rd_chk(8'h20, 1'b0);
      end
   endtask
   task automatic t_recal();
      int n;
      int gap;
      n = 0;
      gap = 0;
      while (imp_recal_pulse !== 1'b1 && n < 9000) begin
         @(posedge clock);
         n++;
      end
      @(posedge clock);
      while (imp_recal_pulse !== 1'b1 && gap < 9000) begin
         @(posedge clock);
         gap++;
      end
      check(18'(gap + 1), 18'(8 * dbsp_pkg::IMP_RECAL_PERIOD));
      if (gap >= 9000) summarize();
   endtask
   task automatic t_stall();
      int n;
      ctl.halt(32);
      check(18'(pll_locked), 18'h00000);
      check(18'(dq_oe_n), 18'h00001);
      wait_lock(n);
   endtask
   task automatic t_bypass();
      pll_enable_n_pin <= 1'b0;
      repeat (16) @(posedge clock);
      wr(8'h30, 18'h0C0DE, 18'h1BEEF, 2'h0, 2'h0);
      rd_chk(8'h30, 1'b1);
   endtask
   initial begin
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      t_start();
      t_posted();
      t_masks();
      t_recal();
      t_stall();
      t_bypass();
      summarize();
   end
endmodule
